// *** hdl/sector_protect_pkg.sv ***
// constants and types shared by the sector protection lock logic
`default_nettype none
package sector_protect_pkg;
  localparam int          SECT_LSB    = 12;        // 4KB sector offset width
  localparam int          BLK_LSB     = 16;        // 64KB block offset width
  localparam int          EDGE_SECTS  = 16;        // sectors in each edge block
  localparam int          CMD_W       = 4;
  localparam int          MODE_W      = 16;
  localparam int          LOCK_W      = 8;
  localparam int          RD_W        = 16;
  localparam int          SOLID_BIT   = 1;         // 0 = solid mode fixed
  localparam int          PASS_BIT    = 2;         // 0 = password mode fixed
  localparam int          LOCK_FLAG   = 0;
  localparam logic [15:0] MODE_RESET  = 16'hFFFF;  // shipped: both select bits one
  localparam logic [7:0]  READ_ONE    = 8'hFF;
  localparam logic [7:0]  READ_ZERO   = 8'h00;

  typedef enum logic [3:0] {
    mode_lock_write_cmd        = 4'h1,
    mode_lock_read_cmd         = 4'h2,
    persist_lock_set_cmd       = 4'h3,
    persist_lock_read_cmd      = 4'h4,
    password_unlock_cmd        = 4'h5,
    persistent_bit_program_cmd = 4'h6,
    persistent_bits_erase_cmd  = 4'h7,
    persistent_bit_read_cmd    = 4'h8,
    dynamic_bit_write_cmd      = 4'h9,
    dynamic_bit_read_cmd       = 4'hA,
    gang_lock_cmd              = 4'hB,
    gang_unlock_cmd            = 4'hC
  } protect_cmd_e;

  typedef enum logic [2:0] {
    st_idle  = 3'h1,
    st_exec  = 3'h2,
    st_reply = 3'h4
  } core_state_e;
endpackage
`default_nettype wire

// *** hdl/sector_protect_lock_logic.sv ***
// sector and block write-protection lock logic with a link-clocked command port
//
// Operation
// - 16-bit one-time mode-lock register; bits 2:1 both one means solid mode.
// - clearing bit 1 fixes solid mode and disables password mode for good.
// - clearing bit 2 fixes password mode and disables solid mode for good.
// - a write clearing bits 1 and 2 together is aborted, neither bit changes.
// - a write clearing more than one bit raises the program-fail flag.
// - once bit 1 or 2 is zero the other bit can no longer change.
// - lock flag is bit 0 of an 8-bit status; one allows changes; rest zero.
// - on reset lock flag is one in solid mode, zero in password mode.
// - lock-set after write enable clears the flag; in solid mode only reset sets it again.
// - in password mode only a correct password unlock sets the flag.
// - one persistent bit per edge 4KB sector and per 64KB block, shipped zero.
// - with protection select one, a region whose persistent bit is one refuses program and erase.
// - program sets one persistent bit; only erase-all clears, clearing every bit.
// - with the lock flag zero, persistent set and clear commands are ignored.
// - persistent read returns 00h for zero and FFh for one.
// - one dynamic bit per region; with protection select one a region is open only if both bits are zero.
// - reset sets every dynamic bit, so every region reads FFh.
// - dynamic write sets or clears one bit; gang unlock clears, gang lock sets all.
// - sector commands act only with protection select one; then block field is off.
// - write-protect pin low protects every region regardless of its bits.
`default_nettype none
module sector_protect_lock_logic
  import sector_protect_pkg::*;
#(
  parameter int ADDR_W = 24
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              hw_reset_n,
  input  wire logic              write_protect_n,
  input  wire logic              write_enable_latch,
  input  wire logic              protection_select_bit,
  input  wire logic              password_match,
  output logic                   block_protect_field_enable,
  output logic                   write_enable_clear,
  output logic                   program_fail_set,
  input  wire logic              pe_req,
  input  wire logic [ADDR_W-1:0] pe_addr,
  output logic                   pe_done,
  output logic                   pe_allowed,
  input  wire logic              link_clk,
  input  wire logic              link_cmd_valid,
  input  wire logic [CMD_W-1:0]  link_cmd,
  input  wire logic [ADDR_W-1:0] link_addr,
  input  wire logic [MODE_W-1:0] link_data,
  output logic                   link_ready,
  output logic                   link_rsp_valid,
  output logic [RD_W-1:0]        link_rsp_data
);
  localparam int NBLK  = 2 ** (ADDR_W - BLK_LSB);
  localparam int NREG  = NBLK - 2 + 2 * EDGE_SECTS;
  localparam int IDX_W = $clog2(NREG);
  localparam int BLK_W = ADDR_W - BLK_LSB;

  if (ADDR_W < BLK_LSB + 2 || ADDR_W > 32) begin : g_check
    $error("ADDR_W must give at least four 64KB blocks and fit 32 bits");
  end

  // region index: edge sectors first, then inner blocks, then top sectors
  function automatic logic [IDX_W-1:0] region_of(input logic [ADDR_W-1:0] a);
    logic [BLK_W-1:0] blk;
    logic [IDX_W-1:0] sec;
    blk = a[ADDR_W-1:BLK_LSB];
    sec = IDX_W'(a[BLK_LSB-1:SECT_LSB]);
    if (blk == '0) begin
      region_of = sec;
    end else if (blk == '1) begin
      region_of = IDX_W'(NBLK - 2 + EDGE_SECTS) + sec;
    end else begin
      region_of = IDX_W'(blk) + IDX_W'(EDGE_SECTS - 1);
    end
  endfunction

  // ---------------- link domain ----------------
  logic             req_toggle;
  logic [CMD_W-1:0] req_cmd;
  logic [ADDR_W-1:0] req_addr;
  logic [MODE_W-1:0] req_data;
  logic             done_meta;
  logic             done_sync;
  logic             done_seen;
  logic             done_toggle;
  logic [RD_W-1:0]  rsp_hold;

  // one request in flight; a command while busy is dropped, ready shows it
  assign link_ready = (req_toggle == done_sync);

  // capture a command; fields stay stable until the core answers
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      req_toggle <= 1'b0;
      req_cmd    <= '0;
      req_addr   <= '0;
      req_data   <= '0;
    end else if (link_cmd_valid && link_ready) begin
      req_toggle <= ~req_toggle;
      req_cmd    <= link_cmd;
      req_addr   <= link_addr;
      req_data   <= link_data;
    end
  end

  // answer toggle back from the core, two flops before use
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      done_meta <= 1'b0;
      done_sync <= 1'b0;
      done_seen <= 1'b0;
    end else begin
      done_meta <= done_toggle;
      done_sync <= done_meta;
      done_seen <= done_sync;
    end
  end

  // answer data is stable in the core while the toggle crosses
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      link_rsp_valid <= 1'b0;
      link_rsp_data  <= '0;
    end else begin
      link_rsp_valid <= (done_sync != done_seen);
      if (done_sync != done_seen) begin
        link_rsp_data <= rsp_hold;
      end
    end
  end

  // ---------------- core domain ----------------
  logic        req_meta;
  logic        req_sync;
  logic        req_seen;
  logic        wp_meta;
  logic        wp_sync;
  logic        hwr_meta;
  logic        hwr_sync;
  core_state_e state;
  core_state_e next_state;
  logic [MODE_W-1:0] mode_lock;
  logic              lock_flag;
  logic [NREG-1:0]   persist_bits;
  logic [NREG-1:0]   dyn_bits;

  // pins and the request toggle pass two flops
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      req_meta <= 1'b0;
      req_sync <= 1'b0;
      req_seen <= 1'b0;
      wp_meta  <= 1'b1;
      wp_sync  <= 1'b1;
      hwr_meta <= 1'b1;
      hwr_sync <= 1'b1;
    end else begin
      req_meta <= req_toggle;
      req_sync <= req_meta;
      req_seen <= req_sync;
      wp_meta  <= write_protect_n;
      wp_sync  <= wp_meta;
      hwr_meta <= hw_reset_n;
      hwr_sync <= hwr_meta;
    end
  end

  wire         new_req   = (req_sync != req_seen);
  wire         exec      = (state == st_exec);
  wire         asp_on    = protection_select_bit;
  wire         pass_mode = ~mode_lock[PASS_BIT];
  wire         hw_rst    = ~hwr_sync;
  wire [IDX_W-1:0] cmd_idx = region_of(req_addr);
  wire         idx_ok    = (32'(cmd_idx) < NREG);

  // in advanced mode the status block-protect field is ignored
  assign block_protect_field_enable = ~asp_on;

  // decoded actions; all sector commands need protection select
  wire act       = exec && asp_on;
  wire act_wel   = act && write_enable_latch;
  wire do_mode   = act_wel && (req_cmd == mode_lock_write_cmd);
  wire do_lkset  = act_wel && (req_cmd == persist_lock_set_cmd);
  wire do_unlock = act && (req_cmd == password_unlock_cmd);
  wire do_pprog  = act_wel && lock_flag && idx_ok
                   && (req_cmd == persistent_bit_program_cmd);
  wire do_perase = act_wel && lock_flag
                   && (req_cmd == persistent_bits_erase_cmd);
  wire do_dwrite = act_wel && idx_ok && (req_cmd == dynamic_bit_write_cmd);
  wire do_glock  = act_wel && (req_cmd == gang_lock_cmd);
  wire do_gulk   = act_wel && (req_cmd == gang_unlock_cmd);
  wire wel_cmd   = do_mode | do_lkset | do_pprog | do_perase
                   | do_dwrite | do_glock | do_gulk;

  // mode-lock write checks: only one-to-zero changes count
  wire [MODE_W-1:0] cleared   = mode_lock & ~req_data;
  wire              multi_clr = ($countones(cleared) > 1);
  wire              fixed     = ~mode_lock[SOLID_BIT] | ~mode_lock[PASS_BIT];
  wire              other_hit = fixed && (cleared[SOLID_BIT] | cleared[PASS_BIT]);
  wire              mode_ok   = do_mode && !multi_clr && !other_hit;

  // command sequencer
  always_comb begin
    next_state = state;
    case (state)
      st_idle:  if (new_req) next_state = st_exec;
      st_exec:  next_state = st_reply;
      st_reply: next_state = st_idle;
      default:  next_state = st_idle;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= st_idle;
    end else begin
      state <= next_state;
    end
  end

  // one-time mode lock: bits only go from one to zero, the reset pin keeps them
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_lock <= MODE_RESET;
    end else if (mode_ok) begin
      mode_lock <= mode_lock & req_data;
    end
  end

  // lock flag: reloaded from the mode on the reset pin; between resets only unlock raises it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lock_flag <= 1'b1;
    end else if (hw_rst) begin
      lock_flag <= ~pass_mode;
    end else if (do_lkset) begin
      lock_flag <= 1'b0;
    end else if (do_unlock && pass_mode && password_match) begin
      lock_flag <= 1'b1;
    end
  end

  // per-region persistent and dynamic protect bits
  for (genvar r = 0; r < NREG; r++) begin : g_region
    wire hit = (32'(cmd_idx) == r);

    // non-volatile: survives the reset pin, only power-on restores shipped zero
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        persist_bits[r] <= 1'b0;
      end else if (do_perase) begin
        persist_bits[r] <= 1'b0;
      end else if (do_pprog && hit) begin
        persist_bits[r] <= 1'b1;
      end
    end

    // volatile: every reset protects the region again
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        dyn_bits[r] <= 1'b1;
      end else if (hw_rst || do_glock) begin
        dyn_bits[r] <= 1'b1;
      end else if (do_gulk) begin
        dyn_bits[r] <= 1'b0;
      end else if (do_dwrite && hit) begin
        dyn_bits[r] <= req_data[0];
      end
    end
  end

  // read answers are registered and held until the next command
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rsp_hold <= '0;
    end else if (exec) begin
      rsp_hold <= '0;
      if (asp_on) begin
        case (req_cmd)
          mode_lock_read_cmd:      rsp_hold <= mode_lock;
          persist_lock_read_cmd:   rsp_hold <= RD_W'({{(LOCK_W-1){1'b0}}, lock_flag});
          persistent_bit_read_cmd:
            rsp_hold <= RD_W'((idx_ok && persist_bits[cmd_idx]) ? READ_ONE : READ_ZERO);
          dynamic_bit_read_cmd:
            rsp_hold <= RD_W'((idx_ok && dyn_bits[cmd_idx]) ? READ_ONE : READ_ZERO);
          default:                 rsp_hold <= '0;
        endcase
      end
    end
  end

  // answer toggle to the link side once data is stable
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      done_toggle <= 1'b0;
    end else if (state == st_reply) begin
      done_toggle <= ~done_toggle;
    end
  end

  // program or erase check, answered one cycle after the request
  wire [IDX_W-1:0] pe_idx   = region_of(pe_addr);
  wire             pe_guard = asp_on && ((32'(pe_idx) >= NREG)
                              || persist_bits[pe_idx] || dyn_bits[pe_idx]);
  wire             pe_block = ~wp_sync || pe_guard;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pe_done    <= 1'b0;
      pe_allowed <= 1'b0;
    end else begin
      pe_done    <= pe_req;
      pe_allowed <= pe_req && !pe_block;
    end
  end

  // status side effects: fail flag and write-enable clear as single pulses
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      program_fail_set   <= 1'b0;
      write_enable_clear <= 1'b0;
    end else begin
      program_fail_set   <= do_mode && (multi_clr || other_hit);
      write_enable_clear <= wel_cmd || (pe_req && pe_block);
    end
  end
endmodule
`default_nettype wire

// *** dv/protect_lock_properties.sv ***
// port-level assertions for the sector protection lock logic
`default_nettype none
module protect_lock_properties (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        write_protect_n,
  input wire logic        protection_select_bit,
  input wire logic        block_protect_field_enable,
  input wire logic        write_enable_clear,
  input wire logic        program_fail_set,
  input wire logic        pe_req,
  input wire logic        pe_done,
  input wire logic        pe_allowed,
  input wire logic        link_clk,
  input wire logic        link_cmd_valid,
  input wire logic        link_ready,
  input wire logic        link_rsp_valid,
  input wire logic [15:0] link_rsp_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // cycles the pin stayed low; three clears the two-flop sync
  logic [1:0] wp_low;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) wp_low <= 2'h0;
    else if (write_protect_n) wp_low <= 2'h0;
    else if (wp_low != 2'h3) wp_low <= wp_low + 2'h1;
  end
  // a command is taken, then the port is busy the next cycle and answers 1 to 40 cycles after that
  sequence cmd_taken;
    link_cmd_valid && link_ready;
  endsequence
  sequence busy_then_answer;
    !link_ready ##[1:40] link_rsp_valid;
  endsequence
  bp_follow_a: assert property (@(posedge clk) disable iff (reset)
    block_protect_field_enable == !protection_select_bit) else $error("bp enable wrong");
  pe_answer_a: assert property (@(posedge clk) disable iff (reset)
    pe_req |=> pe_done) else $error("no pe answer");
  pe_quiet_a: assert property (@(posedge clk) disable iff (reset)
    !pe_req |=> !pe_done) else $error("stray pe answer");
  wp_refuse_a: assert property (@(posedge clk) disable iff (reset)
    pe_req && wp_low == 2'h3 |=> !pe_allowed) else $error("allowed under pin");
  refuse_wel_a: assert property (@(posedge clk) disable iff (reset)
    pe_done && !pe_allowed |-> write_enable_clear) else $error("latch kept");
  fail_pulse_a: assert property (@(posedge clk) disable iff (reset)
    program_fail_set |=> !program_fail_set) else $error("fail not a pulse");
  take_answer_a: assert property (@(posedge link_clk) disable iff (reset)
    cmd_taken |=> busy_then_answer) else $error("no link answer");
  // ready follows the second sync flop, so it rises one link cycle ahead of the answer pulse
  rsp_ready_a: assert property (@(posedge link_clk) disable iff (reset)
    link_rsp_valid |-> link_ready && $past(link_ready) && !$past(link_ready, 2))
    else $error("ready mismatch");
  sel_off_a: assert property (@(posedge link_clk) disable iff (reset)
    link_rsp_valid && !protection_select_bit |-> link_rsp_data == 16'h0000)
    else $error("answer while off");
endmodule
bind sector_protect_lock_logic protect_lock_properties protect_lock_properties_i (
  .clk(clk), .reset(reset), .write_protect_n(write_protect_n),
  .protection_select_bit(protection_select_bit),
  .block_protect_field_enable(block_protect_field_enable),
  .write_enable_clear(write_enable_clear), .program_fail_set(program_fail_set),
  .pe_req(pe_req), .pe_done(pe_done), .pe_allowed(pe_allowed), .link_clk(link_clk),
  .link_cmd_valid(link_cmd_valid), .link_ready(link_ready),
  .link_rsp_valid(link_rsp_valid), .link_rsp_data(link_rsp_data));
`default_nettype wire

// *** dv/protect_host_model.sv ***
// host controller model issuing protection commands on the link
`default_nettype none
module protect_host_model #(
  parameter int AW = 18
) (
  input  wire logic          clk,
  input  wire logic          link_clk,
  input  wire logic          link_ready,
  input  wire logic          link_rsp_valid,
  input  wire logic [15:0]   link_rsp_data,
  output logic               write_enable_latch,
  output logic               link_cmd_valid,
  output logic [3:0]         link_cmd,
  output logic [AW-1:0]      link_addr,
  output logic [15:0]        link_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    write_enable_latch = 1'b0;
    link_cmd_valid = 1'b0;
    link_cmd = 4'h0;
    link_addr = '0;
    link_data = 16'h0000;
  end
  // one command at a time; idle fields are scrambled so stale values never help
  task automatic send(input logic [3:0] c, input logic [AW-1:0] a, input logic [15:0] d,
                      input logic we, output logic [15:0] rsp, output logic ok);
    int n;
    @(negedge clk);
    write_enable_latch = we;
    repeat ($urandom % 3) @(negedge link_clk);
    @(negedge link_clk);
    for (n = 0; link_ready !== 1'b1 && n < 60; n++) @(negedge link_clk);
    link_cmd_valid = 1'b1;
    link_cmd = c;
    link_addr = a;
    link_data = d;
    @(posedge link_clk);
    @(negedge link_clk);
    link_cmd_valid = 1'b0;
    link_cmd = 4'($urandom);
    link_addr = AW'($urandom);
    link_data = 16'($urandom);
    for (n = 0; link_rsp_valid !== 1'b1 && n < 60; n++) @(negedge link_clk);
    ok = n < 60;
    rsp = link_rsp_data;
  endtask
endmodule
`default_nettype wire

// *** dv/sector_protect_lock_logic_tb.sv ***
// self-checking bench for the sector protection lock logic
`default_nettype none
module sector_protect_lock_logic_tb;
  import sector_protect_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int AW = 18;
  localparam int NREG = 34;
  logic clk, link_clk, reset, hw_reset_n, write_protect_n, protection_select_bit;
  logic password_match, write_enable_latch, block_protect_field_enable;
  logic write_enable_clear, program_fail_set, pe_req, pe_done, pe_allowed;
  logic link_cmd_valid, link_ready, link_rsp_valid;
  logic [CMD_W-1:0] link_cmd;
  logic [AW-1:0] pe_addr, link_addr;
  logic [MODE_W-1:0] link_data;
  logic [RD_W-1:0] link_rsp_data;
  int failures, check_count, cycles, fails_seen, fail_exp, mode, flag;
  int per[NREG];
  int dyn[NREG];
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // link clock kept out of phase with the core clock
  initial begin
    link_clk = 1'b0;
    #3.7;
    forever #7.5 link_clk = ~link_clk;
  end
  sector_protect_lock_logic #(.ADDR_W(AW)) sector_protect_lock_logic_i (
    .clk(clk), .reset(reset), .hw_reset_n(hw_reset_n), .write_protect_n(write_protect_n),
    .write_enable_latch(write_enable_latch), .protection_select_bit(protection_select_bit),
    .password_match(password_match), .block_protect_field_enable(block_protect_field_enable),
    .write_enable_clear(write_enable_clear), .program_fail_set(program_fail_set),
    .pe_req(pe_req), .pe_addr(pe_addr), .pe_done(pe_done), .pe_allowed(pe_allowed),
    .link_clk(link_clk), .link_cmd_valid(link_cmd_valid), .link_cmd(link_cmd),
    .link_addr(link_addr), .link_data(link_data), .link_ready(link_ready),
    .link_rsp_valid(link_rsp_valid), .link_rsp_data(link_rsp_data));
  protect_host_model #(.AW(AW)) protect_host_model_i (
    .clk(clk), .link_clk(link_clk), .link_ready(link_ready), .link_rsp_valid(link_rsp_valid),
    .link_rsp_data(link_rsp_data), .write_enable_latch(write_enable_latch),
    .link_cmd_valid(link_cmd_valid), .link_cmd(link_cmd), .link_addr(link_addr),
    .link_data(link_data));
  // fail pulses are counted here; the ceiling cuts a hang short
  always @(posedge clk) begin
    if (program_fail_set === 1'b1) fails_seen++;
    cycles++;
    if (cycles == 30000) begin
      failures++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic int region(input int a);
    int b = a >> 16;
    int s = (a >> 12) & 15;
    return b == 0 ? s : (b == 3 ? 18 + s : b + 15);
  endfunction
  // any byte within the region's first 4KB, low 12 bits random
  function automatic int addr_of(input int r);
    int o = $urandom & 12'hFFF;
    return o | (r < 16 ? r << 12 : (r < 18 ? (r - 15) << 16 : 32'h30000 | ((r - 18) << 12)));
  endfunction
  // reference model: update state and predict the answer, then run it on the link
  task automatic op(input int c, input int a, input int d, input logic we);
    logic [15:0] got;
    logic ok;
    int r, e, clr;
    r = region(a);
    e = 0;
    clr = mode & ~d & 16'hFFFF;
    if (protection_select_bit) begin
      case (c)
        1: if (we && ($countones(clr) > 1 || (clr & 6) != 0 && (mode & 6) != 6)) fail_exp++;
          else if (we) mode = mode & d;
        2: e = mode;
        3: if (we) flag = 0;
        4: e = flag;
        5: if ((mode & 4) == 0 && password_match) flag = 1;
        6: if (we && flag) per[r] = 1;
        7: if (we && flag) foreach (per[i]) per[i] = 0;
        8: e = per[r] ? 16'h00FF : 0;
        9: if (we) dyn[r] = d & 1;
        10: e = dyn[r] ? 16'h00FF : 0;
        11: if (we) foreach (dyn[i]) dyn[i] = 1;
        12: if (we) foreach (dyn[i]) dyn[i] = 0;
        default: e = 0;
      endcase
    end
    protect_host_model_i.send(4'(c), AW'(a), 16'(d), we, got, ok);
    chk("link answered", 16'h0001, {15'h0, ok});
    chk("link answer", 16'(e), got);
  endtask
  // program or erase request; a refusal must also clear the latch
  task automatic pe(input int a);
    logic exp;
    exp = write_protect_n && !(protection_select_bit && (per[region(a)] || dyn[region(a)]));
    @(negedge clk);
    pe_req = 1'b1;
    pe_addr = AW'(a);
    @(negedge clk);
    chk("pe result", {13'h0, exp, !exp, 1'b1},
        {13'h0, pe_allowed, write_enable_clear, pe_done});
    pe_req = 1'b0;
    pe_addr = AW'($urandom);
  endtask
  task automatic sweep();
    for (int r = 0; r < NREG; r++) begin
      op(8, addr_of(r), 0, 0);
      op(10, addr_of(r), 0, 0);
      pe(addr_of(r));
    end
  endtask
  task automatic power_up();
    @(negedge clk);
    reset = 1'b1;
    // two full rising edges under reset, release away from the sampling edge
    repeat (2) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    mode = 16'hFFFF;
    flag = 1;
    foreach (per[i]) per[i] = 0;
    foreach (dyn[i]) dyn[i] = 1;
  endtask
  // hardware reset pin reloads only the volatile bits
  task automatic hw_rst();
    @(negedge clk);
    hw_reset_n = 1'b0;
    repeat (4) @(negedge clk);
    hw_reset_n = 1'b1;
    repeat (4) @(negedge clk);
    flag = (mode >> 2) & 1;
    foreach (dyn[i]) dyn[i] = 1;
  endtask
  initial begin
    void'($urandom(32'h5007));
    {reset, hw_reset_n, write_protect_n, protection_select_bit} = 4'hF;
    {password_match, pe_req, pe_addr} = '0;
    power_up();
    op(2, 0, 0, 0);
    op(4, 0, 0, 0);
    sweep();
    op(12, 0, 0, 1);
    op(6, addr_of(5), 0, 1);
    op(6, addr_of(20), 0, 0);
    op(9, addr_of(30), 1, 1);
    sweep();
    op(7, 0, 0, 1);
    op(11, 0, 0, 1);
    op(9, addr_of(16), 0, 1);
    sweep();
    op(3, 0, 0, 1);
    op(6, addr_of(2), 0, 1);
    op(8, addr_of(2), 0, 0);
    op(4, 0, 0, 0);
    hw_rst();
    op(4, 0, 0, 0);
    @(negedge clk);
    write_protect_n = 1'b0;
    op(12, 0, 0, 1);
    repeat (6) pe($urandom % 32'h40000);
    @(negedge clk);
    write_protect_n = 1'b1;
    protection_select_bit = 1'b0;
    for (int c = 1; c <= 12; c++) op(c, addr_of(c), 0, 1);
    repeat (4) pe($urandom % 32'h40000);
    @(negedge clk);
    protection_select_bit = 1'b1;
    op(1, 0, 16'hFFF9, 1);
    op(1, 0, 16'hFFFD, 1);
    op(1, 0, 16'hFFF9, 1);
    op(2, 0, 0, 0);
    power_up();
    // password mode is fixed with password_match low; the first unlock will not match
    @(negedge clk);
    password_match = 1'b0;
    op(1, 0, 16'hFFFB, 1);
    hw_rst();
    op(4, 0, 0, 0);
    op(6, addr_of(33), 0, 1);
    op(5, 0, 0, 0);
    @(negedge clk);
    password_match = 1'b1;
    op(5, 0, 0, 0);
    op(6, addr_of(33), 0, 1);
    op(8, addr_of(33), 0, 0);
    chk("fail pulses", 16'(fail_exp), 16'(fails_seen));
    test_done();
  end
endmodule
`default_nettype wire
